// >>> bcb_cfg.svh
// offsets, field positions, reset values and timing counts of the clock, buffer
// and timeout configuration bank; included by every design file of the bank except the package
`ifndef BCB_CFG_SVH
`define BCB_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define BCB_OFF_CLK        12'h048
`define BCB_OFF_BUF        12'h04c
`define BCB_OFF_CTO        12'h050

// ****************************************
// reset values and writable masks
// ****************************************
`define BCB_RST_CLK        32'h0000_0100
`define BCB_RST_BUF        32'h0000_0307
`define BCB_RST_CTO        32'h8009_8968
`define BCB_MSK_CLK        32'h0000_010f
`define BCB_MSK_BUF        32'h0000_031f
`define BCB_MSK_CTO        32'hffff_ffff

// ****************************************
// field positions
// ****************************************
`define BCB_PLL_BIT        8
`define BCB_SRC_BIT        3
`define BCB_SPD_LO         0
`define BCB_LIM_LO         8
`define BCB_THR_LO         0
`define BCB_TOEN_BIT       31

// ****************************************
// timing
// ****************************************
`define BCB_CLK_NS         4
`define BCB_TO_UNIT_NS     16
`define BCB_THR_STEP       16
`define BCB_LIM_BASE       128
// secondary clock periods in pclk cycles
`define BCB_PER_25         10
`define BCB_PER_33         8
`define BCB_PER_50         5
`define BCB_PER_66         4

`endif

// >>> bcb_pkg.sv
// types shared by the clock, buffer and timeout configuration bank
// assumes bcb_cfg.svh sits in the same folder
package bcb_pkg;
   typedef enum logic [1:0] {
      bcb_spd_25 = 2'b00,
      bcb_spd_33 = 2'b01,
      bcb_spd_50 = 2'b10,
      bcb_spd_66 = 2'b11
   } bcb_speed_e;
   typedef logic [2:0] bcb_tag_t;
endpackage

// >>> bcb_clk_gen.sv
// secondary clock divider: picks the speed and the duty from the clock settings
// assumes pclk at 250 mhz; secondary periods are whole pclk cycles
`timescale 1ns/1ps
`default_nettype none
`include "bcb_cfg.svh"
module bcb_clk_gen (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // settings
   input  wire logic             pll_freq_select,
   input  wire logic             clock_source_select,
   input  wire logic [2:0]       clock_speed_code,
   input  wire logic             speed_66_strap,
   // clock out
   output logic                  secondary_clock_out,
   output bcb_pkg::bcb_speed_e   speed
);
   import bcb_pkg::*;

   logic [3:0]  cnt;
   logic [3:0]  next_cnt;
   logic        next_out;
   bcb_speed_e  next_speed;
   logic [3:0]  per;
   logic [3:0]  high;

   function automatic logic [3:0] period_of(input bcb_speed_e s);
      case (s)
         bcb_spd_25: period_of = 4'(`BCB_PER_25);
         bcb_spd_33: period_of = 4'(`BCB_PER_33);
         bcb_spd_50: period_of = 4'(`BCB_PER_50);
         default:    period_of = 4'(`BCB_PER_66);
      endcase
   endfunction

   always_comb begin
      if (clock_source_select) begin
         next_speed = bcb_speed_e'(clock_speed_code[1:0]);
      end else if (speed_66_strap) begin
         next_speed = bcb_spd_66;
      end else begin
         next_speed = bcb_spd_33;
      end
      per = period_of(speed);
      // 400 mhz pll gives half duty, 200 mhz gives one third high
      high = pll_freq_select ? (per >> 1) : 4'(per / 4'h3);
      if (high == 4'h0) begin
         high = 4'h1;
      end
      next_cnt = (cnt + 4'h1 >= per || next_speed != speed) ? 4'h0 : cnt + 4'h1;
      next_out = next_cnt < high;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt                 <= 4'h0;
         secondary_clock_out <= 1'b0;
         speed               <= bcb_spd_33;
      end else begin
         cnt                 <= next_cnt;
         secondary_clock_out <= next_out;
         speed               <= next_speed;
      end
   end

   a_source_strap : assert property (@(posedge pclk) disable iff (!presetn)
      !clock_source_select && speed_66_strap |=> speed == bcb_spd_66)
      else $error("strap ignored in strap mode");
   a_source_code : assert property (@(posedge pclk) disable iff (!presetn)
      clock_source_select |=> speed == bcb_speed_e'($past(clock_speed_code[1:0])))
      else $error("speed code not followed");
endmodule // bcb_clk_gen
`default_nettype wire

// >>> bcb_cpl_timer.sv
// per-tag completion timeout counters for upstream non-posted requests
// assumes each tag is issued once and completed or timed out before reuse
`timescale 1ns/1ps
`default_nettype none
`include "bcb_cfg.svh"
module bcb_cpl_timer #(
   parameter int unsigned NTAGS = 8
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // settings
   input  wire logic             timeout_enable,
   input  wire logic [30:0]      timeout_count,
   // requests
   input  wire logic             issue_valid,
   input  wire bcb_pkg::bcb_tag_t issue_tag,
   input  wire logic             cpl_valid,
   input  wire bcb_pkg::bcb_tag_t cpl_tag,
   // timeout answer, treated as an unsupported request completion
   output logic                  ur_valid,
   output bcb_pkg::bcb_tag_t     ur_tag,
   output logic [NTAGS-1:0]      pending
);
   import bcb_pkg::*;

   localparam int unsigned UNIT_CYC = `BCB_TO_UNIT_NS / `BCB_CLK_NS;

   logic [32:0]      cnt [NTAGS];
   logic [32:0]      next_cnt [NTAGS];
   logic [NTAGS-1:0] next_pending;
   logic             next_ur_valid;
   bcb_tag_t         next_ur_tag;
   logic [32:0]      limit;

   always_comb begin
      limit         = 33'(timeout_count) * 33'(UNIT_CYC);
      next_pending  = pending;
      next_ur_valid = 1'b0;
      next_ur_tag   = '0;
      for (int i = NTAGS - 1; i >= 0; i--) begin
         next_cnt[i] = cnt[i];
         if (pending[i] && timeout_enable) begin
            next_cnt[i] = cnt[i] + 33'h1;
            if (cnt[i] + 33'h1 >= limit) begin
               next_ur_valid = 1'b1;
               next_ur_tag   = bcb_tag_t'(i);
            end
         end
      end
      if (next_ur_valid) begin
         next_pending[next_ur_tag] = 1'b0;
      end
      if (cpl_valid) begin
         next_pending[cpl_tag] = 1'b0;
      end
      if (issue_valid) begin
         next_pending[issue_tag] = 1'b1;
         next_cnt[issue_tag]     = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NTAGS; i++) begin
            cnt[i] <= '0;
         end
         pending  <= '0;
         ur_valid <= 1'b0;
         ur_tag   <= '0;
      end else begin
         cnt      <= next_cnt;
         pending  <= next_pending;
         ur_valid <= next_ur_valid;
         ur_tag   <= next_ur_tag;
      end
   end

   a_no_timeout_off : assert property (@(posedge pclk) disable iff (!presetn)
      !timeout_enable |=> !ur_valid)
      else $error("timeout while disabled");
   a_ur_was_pending : assert property (@(posedge pclk) disable iff (!presetn)
      ur_valid |-> $past(pending[next_ur_tag]) && !pending[ur_tag])
      else $error("timeout for idle tag");
   c_timeout_seen : cover property (@(posedge pclk) disable iff (!presetn) ur_valid);
endmodule // bcb_cpl_timer
`default_nettype wire

// >>> bcb_top.sv
// clock, buffer and timeout configuration bank with its apb slave
// assumes one clock pclk; all user inputs synchronous to it
//
// Functional notes
// - pll select 1 runs a 400 mhz pll with half duty clock, 0 a 200 mhz pll with 33/66 duty.
// - with source select 0 the secondary clock is 33 or 66 mhz as the strap says.
// - with source select 1 the speed code sets the clock and the strap is ignored.
// - the speed code ignores bit 2: 00 25, 01 33, 10 50, 11 66 mhz.
// - each non-posted read gets the smaller of its length and the buffer limit.
// - buffer limit codes 11,10,01,00 mean 1024,512,256,128 bytes, reset 11.
// - posted write data is forwarded once the accumulated length reaches the threshold.
// - other forwarding events may forward posted data before the threshold.
// - threshold code 00000 is 16 bytes, 00111 is 128 bytes, reset 00111.
// - with timeout enabled an expired request is completed with unsupported status.
// - with timeout disabled no request times out; the enable resets to 1.
// - the timeout value resets to 0x0009_8968, about 10 ms.
`timescale 1ns/1ps
`default_nettype none
`include "bcb_cfg.svh"
module bcb_top #(
   parameter int unsigned NTAGS = 8
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // secondary clock
   input  wire logic             speed_66_strap,
   output logic                  secondary_clock_out,
   output bcb_pkg::bcb_speed_e   secondary_speed,
   output logic                  pll_freq_400,
   // completion buffer allocation
   input  wire logic             np_read_valid,
   input  wire logic [12:0]      np_read_bytes,
   output logic                  alloc_valid,
   output logic [12:0]           alloc_bytes,
   // upstream posted forwarding
   input  wire logic [11:0]      posted_bytes,
   input  wire logic             posted_other_event,
   output logic                  posted_forward,
   // completion timeout
   input  wire logic             np_issue_valid,
   input  wire bcb_pkg::bcb_tag_t np_issue_tag,
   input  wire logic             cpl_valid,
   input  wire bcb_pkg::bcb_tag_t cpl_tag,
   output logic                  ur_valid,
   output bcb_pkg::bcb_tag_t     ur_tag,
   output logic [NTAGS-1:0]      np_pending
);
   import bcb_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [12:0] limit_bytes(input logic [1:0] code);
      limit_bytes = 13'(`BCB_LIM_BASE) << code;
   endfunction

   function automatic logic [12:0] thresh_bytes(input logic [4:0] code);
      thresh_bytes = (13'(code) + 13'h1) * 13'(`BCB_THR_STEP);
   endfunction

   // ****************************************
   // apb slave
   // ****************************************
   logic [31:0] clk_reg;
   logic [31:0] buf_reg;
   logic [31:0] cto_reg;
   logic [31:0] next_clk_reg;
   logic [31:0] next_buf_reg;
   logic [31:0] next_cto_reg;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        access;
   logic        hit;

   // one wait state: pready rises in the second access cycle
   assign access = psel && penable && pready;

   always_comb begin
      next_clk_reg = clk_reg;
      next_buf_reg = buf_reg;
      next_cto_reg = cto_reg;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      next_pready  = psel && penable && !pready;
      hit          = 1'b1;
      if (paddr == `BCB_OFF_CLK) begin
         next_prdata = clk_reg;
         if (access && pwrite) begin
            next_clk_reg = pwdata & `BCB_MSK_CLK;
         end
      end else if (paddr == `BCB_OFF_BUF) begin
         next_prdata = buf_reg;
         if (access && pwrite) begin
            next_buf_reg = pwdata & `BCB_MSK_BUF;
         end
      end else if (paddr == `BCB_OFF_CTO) begin
         next_prdata = cto_reg;
         if (access && pwrite) begin
            next_cto_reg = pwdata & `BCB_MSK_CTO;
         end
      end else begin
         hit         = 1'b0;
         next_prdata = 32'h0000_0000;
      end
      if (!next_pready) begin
         next_prdata = (access && !pwrite) ? prdata : 32'h0000_0000;
      end
      if (next_pready && !hit) begin
         next_pslverr = 1'b1;
      end
      if (next_pready && pwrite) begin
         next_prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_reg <= `BCB_RST_CLK;
         buf_reg <= `BCB_RST_BUF;
         cto_reg <= `BCB_RST_CTO;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         clk_reg <= next_clk_reg;
         buf_reg <= next_buf_reg;
         cto_reg <= next_cto_reg;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ****************************************
   // secondary clock
   // ****************************************
   logic next_pll_freq_400;

   always_comb begin
      next_pll_freq_400 = clk_reg[`BCB_PLL_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_freq_400 <= 1'b1;
      end else begin
         pll_freq_400 <= next_pll_freq_400;
      end
   end

   bcb_clk_gen u_clk_gen (
      .pclk                (pclk),
      .presetn             (presetn),
      .pll_freq_select     (clk_reg[`BCB_PLL_BIT]),
      .clock_source_select (clk_reg[`BCB_SRC_BIT]),
      .clock_speed_code    (clk_reg[`BCB_SPD_LO +: 3]),
      .speed_66_strap      (speed_66_strap),
      .secondary_clock_out (secondary_clock_out),
      .speed               (secondary_speed)
   );

   // ****************************************
   // completion buffer allocation
   // ****************************************
   logic        next_alloc_valid;
   logic [12:0] next_alloc_bytes;
   logic [12:0] lim;

   always_comb begin
      lim              = limit_bytes(buf_reg[`BCB_LIM_LO +: 2]);
      next_alloc_valid = np_read_valid;
      next_alloc_bytes = alloc_bytes;
      if (np_read_valid) begin
         next_alloc_bytes = (np_read_bytes < lim) ? np_read_bytes : lim;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alloc_valid <= 1'b0;
         alloc_bytes <= 13'h0000;
      end else begin
         alloc_valid <= next_alloc_valid;
         alloc_bytes <= next_alloc_bytes;
      end
   end

   // ****************************************
   // upstream posted forwarding
   // ****************************************
   logic next_posted_forward;

   always_comb begin
      next_posted_forward = (posted_bytes != 12'h000) &&
         ((13'(posted_bytes) >= thresh_bytes(buf_reg[`BCB_THR_LO +: 5])) ||
          posted_other_event);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         posted_forward <= 1'b0;
      end else begin
         posted_forward <= next_posted_forward;
      end
   end

   // ****************************************
   // completion timeout
   // ****************************************
   bcb_cpl_timer #(
      .NTAGS (NTAGS)
   ) u_cpl_timer (
      .pclk           (pclk),
      .presetn        (presetn),
      .timeout_enable (cto_reg[`BCB_TOEN_BIT]),
      .timeout_count  (cto_reg[30:0]),
      .issue_valid    (np_issue_valid),
      .issue_tag      (np_issue_tag),
      .cpl_valid      (cpl_valid),
      .cpl_tag        (cpl_tag),
      .ur_valid       (ur_valid),
      .ur_tag         (ur_tag),
      .pending        (np_pending)
   );

   // ****************************************
   // checks
   // ****************************************
   a_apb_wait_one : assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready)
      else $error("apb answer not after one wait");

   a_apb_unmapped : assert property (@(posedge pclk) disable iff (!presetn)
      pready && !(paddr inside {`BCB_OFF_CLK, `BCB_OFF_BUF, `BCB_OFF_CTO}) |-> pslverr)
      else $error("unmapped access without error");

   a_err_with_ready : assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error outside the answer cycle");

   a_clk_write_lands : assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && paddr == `BCB_OFF_CLK |=> clk_reg == ($past(pwdata) & 32'h0000_010f))
      else $error("clock register write lost");

   a_pll_follows : assert property (@(posedge pclk) disable iff (!presetn)
      pll_freq_400 == $past(clk_reg[`BCB_PLL_BIT]))
      else $error("pll select output stale");

   a_alloc_minimum : assert property (@(posedge pclk) disable iff (!presetn)
      np_read_valid |=> alloc_valid && alloc_bytes <= $past(np_read_bytes)
         && alloc_bytes <= (13'h0080 << $past(buf_reg[9:8]))
         && (alloc_bytes == $past(np_read_bytes)
            || alloc_bytes == (13'h0080 << $past(buf_reg[9:8]))))
      else $error("allocation above minimum");

   a_forward_thresh : assert property (@(posedge pclk) disable iff (!presetn)
      posted_bytes != 12'h000 && 13'(posted_bytes) >= 13'(({8'h00, buf_reg[4:0]} + 13'h1) << 4)
         |=> posted_forward)
      else $error("threshold reached without forwarding");

   a_forward_cause : assert property (@(posedge pclk) disable iff (!presetn)
      posted_forward |-> $past(posted_bytes) != 12'h000)
      else $error("forward with empty buffer");

   // ****************************************
   // coverage
   // ****************************************
   c_apb_write : cover property (@(posedge pclk) disable iff (!presetn) access && pwrite);

   c_forward_early : cover property (@(posedge pclk) disable iff (!presetn)
      posted_other_event ##1 posted_forward);

   c_alloc_capped : cover property (@(posedge pclk) disable iff (!presetn)
      alloc_valid && alloc_bytes == 13'h0400);

   c_pll_200 : cover property (@(posedge pclk) disable iff (!presetn)
      !pll_freq_400 && secondary_clock_out);
endmodule // bcb_top
`default_nettype wire

// >>> bcb_core_model.sv
// upstream core model: issues one non-posted request and returns its completion
// assumes the bench pulses go for one cycle; a cpl_wait of zero never completes
`timescale 1ns/1ps
`default_nettype none
module bcb_core_model (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // bench control
   input  wire logic             go,
   input  wire logic [2:0]       go_tag,
   input  wire logic [7:0]       cpl_wait,
   // timeout answer
   input  wire logic             ur_valid,
   input  wire bcb_pkg::bcb_tag_t ur_tag,
   // requests
   output bcb_pkg::bcb_tag_t     np_issue_tag,
   output logic                  np_issue_valid,
   output bcb_pkg::bcb_tag_t     cpl_tag,
   output logic                  cpl_valid
);
   import bcb_pkg::*;
   logic [7:0] cnt;
   logic [2:0] tag_q;
   // idle tag lines toggle so that a stale tag is never seen as valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_issue_valid <= 1'b0;
         np_issue_tag   <= 3'h0;
         cpl_valid      <= 1'b0;
         cpl_tag        <= 3'h0;
         cnt            <= 8'h00;
         tag_q          <= 3'h0;
      end else begin
         np_issue_valid <= go;
         np_issue_tag   <= go ? go_tag : ~np_issue_tag;
         cpl_valid      <= 1'b0;
         cpl_tag        <= ~cpl_tag;
         if (go) begin
            tag_q <= go_tag;
            cnt   <= cpl_wait;
         end else if (ur_valid && ur_tag == tag_q) begin
            cnt <= 8'h00;
         end else if (cnt == 8'h01) begin
            cpl_valid <= 1'b1;
            cpl_tag   <= tag_q;
            cnt       <= 8'h00;
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule // bcb_core_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the configuration bank
// assumes the apb slave answers with its own pready and the core model above
`timescale 1ns/1ps
`default_nettype none
`include "bcb_cfg.svh"
module tb_top;
   import bcb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, posted_bytes;
   logic [31:0] pwdata, prdata, rv;
   logic speed_66_strap, secondary_clock_out, pll_freq_400, np_read_valid, alloc_valid;
   logic [12:0] np_read_bytes, alloc_bytes;
   logic posted_other_event, posted_forward, np_issue_valid, cpl_valid, ur_valid, go, ev;
   bcb_speed_e secondary_speed;
   bcb_tag_t np_issue_tag, cpl_tag, ur_tag;
   logic [7:0] np_pending, cpl_wait;
   logic [2:0] go_tag;
   int bad_count, checked;
   bcb_top #(.NTAGS(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .speed_66_strap(speed_66_strap),
      .secondary_clock_out(secondary_clock_out), .secondary_speed(secondary_speed),
      .pll_freq_400(pll_freq_400), .np_read_valid(np_read_valid),
      .np_read_bytes(np_read_bytes), .alloc_valid(alloc_valid), .alloc_bytes(alloc_bytes),
      .posted_bytes(posted_bytes), .posted_other_event(posted_other_event),
      .posted_forward(posted_forward), .np_issue_valid(np_issue_valid),
      .np_issue_tag(np_issue_tag), .cpl_valid(cpl_valid), .cpl_tag(cpl_tag),
      .ur_valid(ur_valid), .ur_tag(ur_tag), .np_pending(np_pending));
   bcb_core_model u_core (.pclk(pclk), .presetn(presetn), .go(go), .go_tag(go_tag),
      .cpl_wait(cpl_wait), .ur_valid(ur_valid), .ur_tag(ur_tag),
      .np_issue_tag(np_issue_tag), .np_issue_valid(np_issue_valid), .cpl_tag(cpl_tag),
      .cpl_valid(cpl_valid));
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("counts: %0d checked, %0d bad", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tmo();
      bad_count++;
      print_verdict();
   endtask
   // ****************************************
   // apb master
   // ****************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, ev);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
      apb(1'b0, a, 32'h0, rv, ev);
      chk(rv, exp);
      chk({31'h0, ev}, {31'h0, eexp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk({31'h0, pll_freq_400}, 32'h1);
      chk({30'h0, secondary_speed}, 32'h1);
      rd(`BCB_OFF_CLK, 32'h0000_0100, 1'b0);
      rd(`BCB_OFF_BUF, 32'h0000_0307, 1'b0);
      rd(`BCB_OFF_CTO, 32'h8009_8968, 1'b0);
      wr(12'h054, 32'hffff_ffff);
      rd(12'h054, 32'h0, 1'b1);
      $display("test reset done");
   endtask
   task automatic period(input int exp, input int exp_hi);
      int n, k, h;
      logic prv;
      n = 0;
      k = 0;
      h = 0;
      prv = secondary_clock_out;
      while (k < 2 && n < 100) begin
         @(posedge pclk);
         n++;
         if (secondary_clock_out && !prv) begin
            if (k == 0) n = 0;
            k++;
         end
         if (k == 1 && secondary_clock_out) h++;
         prv = secondary_clock_out;
      end
      if (k < 2) tmo();
      chk(n, exp);
      chk(h, exp_hi);
   endtask
   task automatic t_clock();
      int per[4] = '{`BCB_PER_25, `BCB_PER_33, `BCB_PER_50, `BCB_PER_66};
      wr(`BCB_OFF_CLK, 32'hffff_ffff);
      rd(`BCB_OFF_CLK, 32'h0000_010f, 1'b0);
      for (int c = 0; c < 8; c++) begin
         speed_66_strap <= c[0];
         wr(`BCB_OFF_CLK, 32'h108 | c);
         cyc(25);
         chk({30'h0, secondary_speed}, c & 3);
         period(per[c & 3], per[c & 3] / 2);
      end
      for (int s = 0; s < 2; s++) begin
         speed_66_strap <= s[0];
         wr(`BCB_OFF_CLK, 32'h100 | s);
         cyc(25);
         chk({30'h0, secondary_speed}, s ? 32'h3 : 32'h1);
      end
      wr(`BCB_OFF_CLK, 32'h0);
      cyc(3);
      chk({31'h0, pll_freq_400}, 32'h0);
      period(`BCB_PER_66, `BCB_PER_66 / 3);
      wr(`BCB_OFF_CLK, 32'h100);
      $display("test clock done");
   endtask
   task automatic t_alloc();
      logic [12:0] ln[2] = '{13'd300, 13'h1fff};
      wr(`BCB_OFF_BUF, 32'hffff_ffff);
      rd(`BCB_OFF_BUF, 32'h0000_031f, 1'b0);
      for (int l = 0; l < 4; l++) begin
         wr(`BCB_OFF_BUF, (l << 8) | 7);
         for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            np_read_valid <= 1'b1;
            np_read_bytes <= ln[i];
            @(posedge pclk);
            np_read_valid <= 1'b0;
            @(posedge pclk);
            chk({31'h0, alloc_valid}, 32'h1);
            chk(alloc_bytes, (ln[i] < (128 << l)) ? ln[i] : (128 << l));
         end
      end
      $display("test alloc done");
   endtask
   task automatic fwd(input logic [11:0] b, input logic e, input logic exp);
      @(posedge pclk);
      posted_bytes       <= b;
      posted_other_event <= e;
      cyc(2);
      chk({31'h0, posted_forward}, {31'h0, exp});
   endtask
   task automatic t_thr();
      int cs[3] = '{0, 7, 31};
      for (int i = 0; i < 3; i++) begin
         wr(`BCB_OFF_BUF, 32'h300 | cs[i]);
         fwd((cs[i] + 1) * 16 - 1, 1'b0, 1'b0);
         fwd((cs[i] + 1) * 16, 1'b0, 1'b1);
      end
      fwd(12'h001, 1'b1, 1'b1);
      fwd(12'h000, 1'b1, 1'b0);
      fwd(12'h001, 1'b0, 1'b0);
      $display("test threshold done");
   endtask
   task automatic req(input logic [2:0] t, input logic [7:0] w);
      @(posedge pclk);
      go       <= 1'b1;
      go_tag   <= t;
      cpl_wait <= w;
      @(posedge pclk);
      go <= 1'b0;
   endtask
   task automatic wait_ur(input int lo, input int hi, input logic [2:0] t);
      int n;
      n = 0;
      while (ur_valid !== 1'b1 && n < hi) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, n >= lo && n < hi}, 32'h1);
      chk(ur_tag, t);
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge pclk);
         chk({31'h0, ur_valid}, 32'h0);
      end
   endtask
   task automatic t_cto();
      wr(`BCB_OFF_CTO, 32'h8000_0002);
      req(3'h3, 8'h00);
      wait_ur(9, 17, 3'h3);
      req(3'h1, 8'h03);
      quiet(30);
      chk(np_pending, 32'h0);
      wr(`BCB_OFF_CTO, 32'h0000_0002);
      req(3'h2, 8'h00);
      quiet(30);
      chk(np_pending, 32'h4);
      wr(`BCB_OFF_CTO, 32'h8000_0002);
      wait_ur(0, 17, 3'h2);
      wr(`BCB_OFF_CTO, 32'h8000_0000);
      req(3'h4, 8'h00);
      wait_ur(1, 5, 3'h4);
      wr(`BCB_OFF_CTO, 32'h8009_8968);
      $display("test timeout done");
   endtask
   // ****************************************
   // clock, reset and main sequence
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {speed_66_strap, np_read_valid, np_read_bytes, posted_bytes} = '0;
      {posted_other_event, go, go_tag, cpl_wait} = '0;
      bad_count = 0;
      checked = 0;
      cyc(10);
      presetn <= 1'b1;
      t_reset();
      t_clock();
      t_alloc();
      t_thr();
      t_cto();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
